//--- rtl/xpr_pkg.sv
// Constants shared by the panel readout: geometry, timing and pixel format.
package xpr_pkg;

  // ****************************************
  // Clock and documented times
  // ****************************************
  localparam int CLK_MHZ = 25;       // Core clock rate
  localparam int TVD_US = 190;       // Trigger to frame delay, external mode
  localparam int TVC_MS = 124;       // Vertical cycle time, internal mode
  localparam int TVDPW_US = 400;     // Dummy vertical pulse width
  localparam int TVD_CYC = TVD_US * CLK_MHZ;
  localparam int TVC_CYC = TVC_MS * 1000 * CLK_MHZ;
  localparam int TVDPW_CYC = TVDPW_US * CLK_MHZ;

  // ****************************************
  // Pixel format and array geometry
  // ****************************************
  localparam int PIX_W = 12;          // Bits per pixel word
  localparam int AMP_ARRAYS = 16;     // Charge amplifier arrays
  localparam int AMP_CH = 312;        // Channels per array
  localparam int COLS = AMP_ARRAYS * AMP_CH;
  localparam int TOTAL_COLS = 2496;
  localparam int TOTAL_ROWS = 2304;
  localparam int ACT_COLS = 2472;
  localparam int ACT_ROWS = 2184;
  localparam int HALF_ROWS = ACT_ROWS / 2;
  localparam int UPPER_LAST_ROW = 1091;
  localparam int LOWER_FIRST_ROW = 1092;
  localparam int LOWER_LAST_ROW = 2183;
  localparam int DUMMY_LINES = 60;    // Dummy lines per port and frame
  localparam int H_DUMMY = 24;        // Dummy words leading each line
  localparam int H_BLANK = 16;        // Pixel clocks with line sync low
  localparam int ROW_W = 12;          // Width of a row index

endpackage : xpr_pkg

//--- rtl/xpr_pair_buf.sv
// Small valid/ready buffer holding pixel pairs between converter and output.
`timescale 1ns/1ns
module xpr_pair_buf
  import xpr_pkg::*;
#(
  parameter int W = 24,
  parameter int DEPTH = 2
) (
  input wire logic mclk_in,             // Core clock
  input wire logic arst_n_in,           // Asynchronous reset, active low
  input wire logic in_valid_in,         // Writer offers a word
  output logic in_ready_out,            // Buffer can take a word
  input wire logic [W-1:0] in_data_in,  // Word offered
  output logic out_valid_out,           // Buffer holds a word
  input wire logic out_ready_in,        // Reader takes the word
  output logic [W-1:0] out_data_out     // Oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("xpr_pair_buf: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
  } xpr_buf_t;

  xpr_buf_t r_reg;
  xpr_buf_t r_next;
  logic push;
  logic pop;

  // ****************************************
  // Handshakes and next state
  // ****************************************
  assign in_ready_out = (r_reg.fill != (AW+1)'(DEPTH));
  assign out_valid_out = (r_reg.fill != '0);
  assign out_data_out = r_reg.mem[r_reg.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;

  // Write, read and fill bookkeeping
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data_in;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: r_next.fill = r_reg.fill + 1'b1;
      2'b01: r_next.fill = r_reg.fill - 1'b1;
      default: r_next.fill = r_reg.fill;
    endcase
  end

  // State register
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : xpr_pair_buf

//--- rtl/xpr_readout.sv
// Frame and line timing of the dual-port panel video output with trigger modes.
`timescale 1ns/1ns
// Notes on behaviour
// - Each pixel leaves as a 12-bit word on two concurrent parallel ports.
// - Line width is at most sixteen arrays of 312 channels, 4992 columns; default line is 2496 words.
// - Array is 2496 by 2304; active region 2472 by 2184.
// - Frame sync, line sync and pixel clock accompany the video words.
// - Internal mode should free-run near 8 frames per second, never below 7.6; with default geometry the code gives about 4.
// - External mode frames follow triggers, from internal rate down to 1 per second.
// - External mode: frame output starts 190 us after trigger rising edge.
// - Internal mode should repeat the frame sync every 124 ms; with default geometry the code repeats it every 248 ms.
// - Line sync, pixel clock and data timing equal in both modes.
// - Rows 0 to 1091 are upper half, 1092 to 2183 lower half.
module xpr_readout
  import xpr_pkg::*;
#(
  parameter int FRAME_CYC = TVC_CYC,      // Internal frame period in clocks
  parameter int DELAY_CYC = TVD_CYC,      // Trigger delay in clocks
  parameter int VS_CYC = TVDPW_CYC,       // Frame sync pulse width in clocks
  parameter int LINE_PIX = TOTAL_COLS,    // Words per line with line sync high
  parameter int HBLANK_PIX = H_BLANK,     // Pixel clocks between lines
  parameter int HDUMMY_PIX = H_DUMMY,     // Dummy words at line start
  parameter int DUMMY_LN = DUMMY_LINES,   // Dummy lines per port
  parameter int HALF_LN = HALF_ROWS       // Effective lines per port
) (
  input wire logic mclk_in,                     // Core clock, 25 MHz
  input wire logic arst_n_in,                   // Asynchronous reset, active low
  input wire logic grabber_trigger_in,          // Trigger from grabber side, idle high
  input wire logic connector_trigger_in,        // Trigger from connector, idle high
  input wire logic trigger_source_select_in,    // Low internal, high external
  input wire logic [PIX_W-1:0] pix_upper_in,    // Converted upper-half sample
  input wire logic [PIX_W-1:0] pix_lower_in,    // Converted lower-half sample
  input wire logic pix_valid_in,                // Sample pair offered
  output logic pix_ready_out,                   // Sample pair taken
  output logic vsync_out,                       // Frame sync, high at frame start
  output logic hsync_out,                       // Line sync, high over a line
  output logic pclk_out,                        // Pixel clock, sample on rising edge
  output logic [PIX_W-1:0] data_a_out,          // Port A word
  output logic [PIX_W-1:0] data_b_out,          // Port B word
  output logic [ROW_W-1:0] row_a_out,           // Image row on port A
  output logic [ROW_W-1:0] row_b_out,           // Image row on port B
  output logic frame_busy_out,                  // Delay or frame in progress
  output logic underrun_out                     // Pulse: word missing from buffer
);

  localparam int CW = $clog2(FRAME_CYC + DELAY_CYC + VS_CYC + 1);
  localparam int PW = $clog2(LINE_PIX + HBLANK_PIX + 1);
  localparam int LW = $clog2(DUMMY_LN + HALF_LN + 1);
  localparam int LAST_LN = DUMMY_LN + HALF_LN - 1;

  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (LINE_PIX > COLS || LINE_PIX <= HDUMMY_PIX || HBLANK_PIX < 1) begin : g_bad_line
      $error("xpr_readout: line length out of range");
    end
    if (HALF_LN > HALF_ROWS || DUMMY_LN < 1 || VS_CYC < 1 || DELAY_CYC < 1) begin : g_bad_frm
      $error("xpr_readout: frame geometry out of range");
    end
    if (FRAME_CYC < 2 || ACT_ROWS > TOTAL_ROWS || ACT_COLS > TOTAL_COLS) begin : g_bad_per
      $error("xpr_readout: frame period too short");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VSYNC = 2'b01,
    ST_HBLANK = 2'b11,
    ST_LINE = 2'b10
  } xpr_st_t;

  typedef struct packed {
    logic [2:0] sy1;           // First sync stage: inverted trigger pins, select
    logic [2:0] sy2;           // Second sync stage
    logic trig_lo_d;           // Combined trigger was low one cycle ago
    xpr_st_t st;
    logic pend;                // Trigger delay running
    logic [CW-1:0] per;        // Internal frame period counter
    logic [CW-1:0] cnt;        // Delay and frame sync counter
    logic [PW-1:0] pix;
    logic [LW-1:0] line;
    logic pclk;
    logic vs;
    logic hs;
    logic [PIX_W-1:0] da;
    logic [PIX_W-1:0] db;
    logic [ROW_W-1:0] ra;
    logic [ROW_W-1:0] rb;
    logic unr;
  } xpr_state_t;

  xpr_state_t r_reg;
  xpr_state_t r_next;
  logic buf_valid;
  logic buf_pop;
  logic [2*PIX_W-1:0] buf_data;

  // ****************************************
  // Sample pair buffer
  // ****************************************
  xpr_pair_buf #(
    .W(2 * PIX_W),
    .DEPTH(2)
  ) u_buf (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(pix_valid_in),
    .in_ready_out(pix_ready_out),
    .in_data_in({pix_upper_in, pix_lower_in}),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_pop),
    .out_data_out(buf_data)
  );

  // ****************************************
  // Trigger, frame and line sequencing
  // ****************************************
  always_comb begin
    logic ext;
    logic trig;
    logic start;
    logic ld;
    logic eff_a;
    logic eff_b;
    logic [PW-1:0] np;
    logic [LW-1:0] nl;
    ext = r_reg.sy2[0];
    trig = ~r_reg.sy2[2] & ~r_reg.sy2[1];  // Both pins high
    start = 1'b0;
    ld = 1'b0;
    np = r_reg.pix;
    nl = r_reg.line;
    eff_a = 1'b0;
    eff_b = 1'b0;
    buf_pop = 1'b0;
    r_next = r_reg;
    // Trigger pins kept inverted so the all-zero reset state reads as idle high: no false edge
    r_next.sy1 = {~grabber_trigger_in, ~connector_trigger_in, trigger_source_select_in};
    r_next.sy2 = r_reg.sy1;
    r_next.trig_lo_d = ~trig;
    r_next.pclk = ~r_reg.pclk;           // Free-running in both modes
    r_next.unr = 1'b0;
    // Internal period: a start tick every FRAME_CYC clocks, used only when idle
    if (ext || r_reg.per == CW'(FRAME_CYC - 1)) begin
      r_next.per = '0;
    end else begin
      r_next.per = r_reg.per + 1'b1;
    end
    if (!ext && r_reg.per == CW'(FRAME_CYC - 1)) begin
      start = 1'b1;
    end
    // External trigger: rising edge arms the delay when idle
    if (!ext) begin
      r_next.pend = 1'b0;
    end else if (r_reg.pend) begin
      if (r_reg.cnt == CW'(DELAY_CYC - 1)) begin
        r_next.pend = 1'b0;
        start = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end else if (trig && r_reg.trig_lo_d && r_reg.st == ST_IDLE) begin
      r_next.pend = 1'b1;
      r_next.cnt = '0;
    end
    case (r_reg.st)
      ST_IDLE: begin
        if (start) begin
          r_next.st = ST_VSYNC;
          r_next.vs = 1'b1;
          r_next.cnt = '0;
        end
      end
      ST_VSYNC: begin
        if (r_reg.cnt == CW'(VS_CYC - 1)) begin
          r_next.vs = 1'b0;
          r_next.st = ST_HBLANK;
          r_next.line = '0;
          r_next.pix = '0;
          r_next.cnt = '0;
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      ST_HBLANK: begin
        if (r_reg.pclk) begin            // Falling edge of the pixel clock
          if (r_reg.pix == PW'(HBLANK_PIX - 1)) begin
            r_next.st = ST_LINE;
            r_next.hs = 1'b1;
            np = '0;
            ld = 1'b1;
          end else begin
            np = r_reg.pix + 1'b1;
          end
          r_next.pix = np;
        end
      end
      ST_LINE: begin
        if (r_reg.pclk) begin
          if (r_reg.pix == PW'(LINE_PIX - 1)) begin
            r_next.hs = 1'b0;
            r_next.da = '0;
            r_next.db = '0;
            r_next.pix = '0;
            nl = r_reg.line + 1'b1;
            r_next.line = nl;
            r_next.st = (r_reg.line == LW'(LAST_LN)) ? ST_IDLE : ST_HBLANK;
          end else begin
            np = r_reg.pix + 1'b1;
            r_next.pix = np;
            ld = 1'b1;
          end
        end
      end
      default: begin
        r_next.st = ST_IDLE;
        r_next.vs = 1'b0;
        r_next.hs = 1'b0;
      end
    endcase
    // Load the word pair for pixel np of line nl
    if (ld) begin
      eff_a = (nl >= LW'(DUMMY_LN));
      eff_b = (nl < LW'(HALF_LN));
      r_next.ra = eff_a ? ROW_W'(nl - LW'(DUMMY_LN)) : '0;
      r_next.rb = eff_b ? ROW_W'(nl) + ROW_W'(LOWER_FIRST_ROW) : '0;
      r_next.da = '0;
      r_next.db = '0;
      if (np >= PW'(HDUMMY_PIX) && (eff_a || eff_b)) begin  // No pair spent on all-dummy words
        if (buf_valid) begin
          buf_pop = 1'b1;
          r_next.da = eff_a ? buf_data[2*PIX_W-1:PIX_W] : '0;
          r_next.db = eff_b ? buf_data[PIX_W-1:0] : '0;
        end else begin
          r_next.unr = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign vsync_out = r_reg.vs;
  assign hsync_out = r_reg.hs;
  assign pclk_out = r_reg.pclk;
  assign data_a_out = r_reg.da;
  assign data_b_out = r_reg.db;
  assign row_a_out = r_reg.ra;
  assign row_b_out = r_reg.rb;
  assign frame_busy_out = r_reg.pend | (r_reg.st != ST_IDLE);
  assign underrun_out = r_reg.unr;

  // ****************************************
  // Checks
  // ****************************************
  logic [CW-1:0] vs_len;
  logic [CW-1:0] dly_len;
  logic [CW-1:0] gap_len;
  logic gap_seen;

  // Helper counters: sync width, trigger delay and frame spacing
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vs_len <= '0;
      dly_len <= '0;
      gap_len <= '0;
      gap_seen <= 1'b0;
    end else begin
      vs_len <= vsync_out ? vs_len + 1'b1 : '0;
      dly_len <= r_reg.pend ? dly_len + 1'b1 : '0;
      if (r_reg.sy2[0]) begin
        gap_len <= '0;
        gap_seen <= 1'b0;
      end else if (vsync_out && !r_reg.st[1] && vs_len == '0) begin
        gap_len <= CW'(1);
        gap_seen <= 1'b1;
      end else begin
        gap_len <= gap_len + 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  chk_data_edge: assert property (
    ($changed(data_a_out) || $changed(data_b_out)) |-> $fell(pclk_out))
    else $error("data changed away from pixel clock fall");
  chk_hsync_edge: assert property (
    $changed(hsync_out) |-> $fell(pclk_out))
    else $error("line sync changed away from pixel clock fall");
  chk_vsync_width: assert property (
    $fell(vsync_out) |-> vs_len == CW'(VS_CYC) && r_reg.st == ST_HBLANK)
    else $error("frame sync width wrong");
  chk_ext_delay: assert property (
    $rose(vsync_out) && $past(r_reg.pend) |-> $past(dly_len) == CW'(DELAY_CYC - 1))
    else $error("trigger to frame delay wrong");
  chk_int_period: assert property (
    $rose(vsync_out) && !r_reg.sy2[0] && gap_seen |-> (int'(gap_len) % FRAME_CYC) == 0)
    else $error("internal frame period wrong");
  chk_dummy_a: assert property (
    hsync_out && r_reg.line < LW'(DUMMY_LN) |-> data_a_out == '0 && row_a_out == '0)
    else $error("port A not dummy in leading lines");
  chk_dummy_b: assert property (
    hsync_out && r_reg.line >= LW'(HALF_LN) |-> data_b_out == '0 && row_b_out == '0)
    else $error("port B not dummy in trailing lines");
  chk_row_halves: assert property (
    hsync_out |-> row_a_out <= ROW_W'(UPPER_LAST_ROW)
      && (row_b_out == '0 || (row_b_out >= ROW_W'(LOWER_FIRST_ROW)
      && row_b_out <= ROW_W'(LOWER_LAST_ROW))))
    else $error("row index outside its half");

endmodule : xpr_readout

//--- verification/xpr_grab_model.sv
// Frame grabber model: drives the trigger pins and captures both video ports.
`timescale 1ns/1ns
module xpr_grab_model
  import xpr_pkg::*;
(
  input wire logic mclk_in,            // Core clock
  input wire logic vsync_in,           // Frame sync
  input wire logic hsync_in,           // Line sync
  input wire logic pclk_in,            // Pixel clock
  input wire logic underrun_in,        // Missing word pulse
  input wire logic [PIX_W-1:0] da_in,  // Port A word
  input wire logic [PIX_W-1:0] db_in,  // Port B word
  input wire logic [ROW_W-1:0] ra_in,  // Port A row
  input wire logic [ROW_W-1:0] rb_in,  // Port B row
  output logic grb_trig_out,           // Grabber trigger, idle high
  output logic con_trig_out,           // Connector trigger, idle high
  output logic sel_out,                // Source select, high external
  output logic stb_out,                // Pulse: pair captured
  output logic und_out,                // Pair met an underrun
  output logic [PIX_W-1:0] a_out,      // Captured port A word
  output logic [PIX_W-1:0] b_out,      // Captured port B word
  output logic [ROW_W-1:0] ra_out,     // Captured port A row
  output logic [ROW_W-1:0] rb_out,     // Captured port B row
  output logic [15:0] pos_out,         // Word index in line
  output logic [15:0] line_out         // Line index in frame
);
  logic und_q;
  logic hs_q;
  logic [15:0] line_cnt;

  // Idle levels: both trigger pins high, internal mode
  initial begin
    grb_trig_out = 1'b1;
    con_trig_out = 1'b1;
    sel_out = 1'b0;
    stb_out = 1'b0;
    und_q = 1'b0;
    hs_q = 1'b0;
    line_cnt = 16'h0000;
  end

  // Short low pulse on one pin; the unused pin stays high
  task automatic send_trigger(input logic use_con);
    @(posedge mclk_in);
    if (use_con) begin
      con_trig_out <= 1'b0;
    end else begin
      grb_trig_out <= 1'b0;
    end
    repeat (4) @(posedge mclk_in);
    con_trig_out <= 1'b1;
    grb_trig_out <= 1'b1;
  endtask : send_trigger

  // Trigger source choice
  task automatic set_external(input logic ext);
    @(posedge mclk_in);
    sel_out <= ext;
  endtask : set_external

  // Capture during each high pixel clock phase with line sync high, both ports together
  always @(posedge mclk_in) begin
    stb_out <= 1'b0;
    und_q <= underrun_in;
    if (vsync_in) begin
      line_cnt <= 16'h0000;
    end
    if (pclk_in) begin
      hs_q <= hsync_in;
      if (hsync_in) begin
        stb_out <= 1'b1;
        und_out <= underrun_in | und_q;
        a_out <= da_in;
        b_out <= db_in;
        ra_out <= ra_in;
        rb_out <= rb_in;
        pos_out <= hs_q ? pos_out + 16'h0001 : 16'h0000;
        if (!hs_q) begin
          line_out <= line_cnt;
          line_cnt <= line_cnt + 16'h0001;
        end
      end
    end
  end
endmodule : xpr_grab_model

//--- verification/testbench.sv
// Self-checking bench of the panel readout against a queue model of the stream.
`timescale 1ns/1ns
module testbench
  import xpr_pkg::*;
;
  // ********
  // Settings and signals
  // ********
  localparam int FRAME_P = 1000;
  localparam int DELAY_P = 20;
  localparam int VS_P = 8;
  localparam int LINE_P = 40;
  localparam int HDUM_P = 4;
  localparam int DUM_P = 2;
  localparam int HALF_P = 4;
  logic mclk_in, arst_n_in, grb, con, sel, valid, ready, vsync, hsync, pclk, busy, und;
  logic w_stb, w_und, stall, per_chk, trig_wait, vs_q, trg_q;
  logic [PIX_W-1:0] up_in, lo_in, da, db, w_a, w_b;
  logic [ROW_W-1:0] ra, rb, w_ra, w_rb;
  logic [15:0] w_pos, w_line;
  logic [PIX_W-1:0] q_up[$];
  logic [PIX_W-1:0] q_lo[$];
  int seed = 21713;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc, trg_cyc, vs_cyc, vs_cnt, vs_w, words, und_cnt, n0;

  xpr_readout #(.FRAME_CYC(FRAME_P), .DELAY_CYC(DELAY_P), .VS_CYC(VS_P), .LINE_PIX(LINE_P),
    .HBLANK_PIX(4), .HDUMMY_PIX(HDUM_P), .DUMMY_LN(DUM_P), .HALF_LN(HALF_P)) i_dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .grabber_trigger_in(grb),
    .connector_trigger_in(con), .trigger_source_select_in(sel), .pix_upper_in(up_in),
    .pix_lower_in(lo_in), .pix_valid_in(valid), .pix_ready_out(ready), .vsync_out(vsync),
    .hsync_out(hsync), .pclk_out(pclk), .data_a_out(da), .data_b_out(db), .row_a_out(ra),
    .row_b_out(rb), .frame_busy_out(busy), .underrun_out(und));

  xpr_grab_model i_grab (
    .mclk_in(mclk_in), .vsync_in(vsync), .hsync_in(hsync), .pclk_in(pclk),
    .underrun_in(und), .da_in(da), .db_in(db), .ra_in(ra), .rb_in(rb), .grb_trig_out(grb),
    .con_trig_out(con), .sel_out(sel), .stb_out(w_stb), .und_out(w_und), .a_out(w_a),
    .b_out(w_b), .ra_out(w_ra), .rb_out(w_rb), .pos_out(w_pos), .line_out(w_line));

  // ********
  // Tasks
  // ********
  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : compare

  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // Bounded waits; running out counts as a mismatch
  task automatic wait_vsync(input int n);
    int target;
    target = vs_cnt + n;
    for (int i = 0; i < 3 * FRAME_P * n && vs_cnt < target; i++) @(negedge mclk_in);
    if (vs_cnt < target) compare(0, 1, "wait for frame sync ran out");
    if (vs_cnt < target) give_verdict();
  endtask : wait_vsync

  task automatic wait_idle();
    for (int i = 0; i < 4 * FRAME_P && busy; i++) @(negedge mclk_in);
    if (busy) compare(0, 1, "wait for idle ran out");
    if (busy) give_verdict();
  endtask : wait_idle

  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  // Sample source: random pairs, held while refused
  always @(posedge mclk_in) begin
    if (arst_n_in && (!valid || ready)) begin
      valid <= stall ? (($random(seed) & 3) == 0) : 1'b1;
      up_in <= PIX_W'($random(seed));
      lo_in <= PIX_W'($random(seed));
    end
  end

  // Reference model: queue of taken pairs, frame timing and word checks
  always @(posedge mclk_in) begin
    logic ae, be;
    logic [PIX_W-1:0] eu, el;
    cyc++;
    if (valid && ready) begin
      q_up.push_back(up_in);
      q_lo.push_back(lo_in);
    end
    if (grb && con && !trg_q) trg_cyc = cyc;
    trg_q = grb & con;
    if (vsync && !vs_q) begin
      if (per_chk && vs_cnt > 0) compare(cyc - vs_cyc, FRAME_P, "frame period");
      if (vs_cnt > 0) compare(words, (DUM_P + HALF_P) * LINE_P, "frame words");
      if (trig_wait) compare((cyc - trg_cyc - DELAY_P) inside {[2:7]}, 1, "delay");
      trig_wait = 1'b0;
      vs_cyc = cyc;
      vs_cnt++;
      words = 0;
      vs_w = 0;
    end
    if (vsync) vs_w++;
    if (!vsync && vs_q) compare(vs_w, VS_P, "frame sync width");
    vs_q = vsync;
    if (w_stb) begin
      ae = w_pos >= HDUM_P && w_line >= DUM_P;
      be = w_pos >= HDUM_P && w_line < HALF_P;
      eu = 12'h000;
      el = 12'h000;
      words++;
      if (w_und) und_cnt++;
      if ((ae || be) && !w_und && q_up.size() > 0) begin
        eu = q_up.pop_front();
        el = q_lo.pop_front();
      end
      compare(w_a, ae ? eu : 12'h000, "port a word");
      compare(w_b, be ? el : 12'h000, "port b word");
      if (ae) compare(w_ra, w_line - DUM_P, "port a row");
      if (be) compare(w_rb, LOWER_FIRST_ROW + w_line, "port b row");
      compare(w_pos < LINE_P && w_line < DUM_P + HALF_P, 1, "line shape");
    end
  end

  // Main sequence
  initial begin
    {cyc, trg_cyc, vs_cyc, vs_cnt, vs_w, words, und_cnt} = '0;
    {stall, per_chk, trig_wait, vs_q, trg_q} = 5'h01;
    arst_n_in = 1'b0;
    valid = 1'b0;
    up_in = 12'h000;
    lo_in = 12'h000;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    compare(ready, 1'b0, "buffer refuses when full");
    per_chk = 1'b1;
    wait_vsync(3);
    compare(und_cnt, 0, "no underrun at full supply");
    stall = 1'b1;
    wait_vsync(2);
    stall = 1'b0;
    compare(und_cnt > 0, 1'b1, "underrun under stall");
    per_chk = 1'b0;
    i_grab.set_external(1'b1);
    repeat (6) @(negedge mclk_in);
    wait_idle();
    n0 = vs_cnt;
    repeat (FRAME_P + 200) @(negedge mclk_in);
    compare(vs_cnt, n0, "no free run when triggered");
    for (int s = 0; s < 2; s++) begin
      n0 = vs_cnt;
      trig_wait = 1'b1;
      i_grab.send_trigger(s[0]);
      repeat (40) @(posedge mclk_in);
      compare(busy, 1'b1, "busy while delay or frame runs");
      i_grab.send_trigger(s[0]);
      @(negedge mclk_in);
      // The repeated trigger fell inside the frame; the next trigger only once the frame has left
      wait_idle();
      repeat (20) @(negedge mclk_in);
      compare(vs_cnt - n0, 1, "one frame per trigger");
      compare(trig_wait, 1'b0, "frame follows trigger");
    end
    give_verdict();
  end
endmodule : testbench
